// file: core/cvp_consts.svh
// Constants for the cell voltage protection logic
`ifndef CVP_CONSTS_SVH
`define CVP_CONSTS_SVH

// Field widths
`define CVP_CODE_W         12
`define CVP_TMR_W          11
`define CVP_TCNT_W         12
`define CVP_PRE_W          20
`define CVP_SEC_W          10
`define CVP_LO_W           3

// Threshold reset values, 12-bit codes over 0 V to 4.8 V; timer reset code, 11 bits
`define CVP_DEF_OVLO       12'hE80
`define CVP_DEF_UVLO       12'h600
`define CVP_DEF_OV         12'hE2A
`define CVP_DEF_OVR        12'hDD5
`define CVP_DEF_UV         12'h900
`define CVP_DEF_UVR        12'hA00
`define CVP_DEF_SLV        12'h6AA
`define CVP_DEF_LVCH       12'h7AA
`define CVP_DEF_TMR        11'h201

// Timer code layout: unit select bit, count top bit, count low bits
`define CVP_TMR_UNIT_BIT   9
`define CVP_TMR_MSB_BIT    10
`define CVP_TMR_LOW_MSB    8

// Timing
`define CVP_CLK_PERIOD_PS  4000
`define CVP_MS_PS          1000000000
`define CVP_MS_PER_S       1000
`define CVP_UV_REL_EXTRA_S 3
`define CVP_LO_SAMPLES     5

`endif

// file: core/cvp_pkg.sv
// Types shared by the cell voltage protection logic
`include "cvp_consts.svh"
package cvp_pkg;

    // Protection state of one condition
    typedef enum logic [0:0] {
        CVP_CLEAR = 1'h0,
        CVP_TRIP  = 1'h1
    } cvp_prot_t;

    // Threshold and timer configuration
    typedef struct packed {
        logic [`CVP_CODE_W-1:0] ov_lockout_threshold;
        logic [`CVP_CODE_W-1:0] uv_lockout_threshold;
        logic [`CVP_CODE_W-1:0] ov_threshold;
        logic [`CVP_CODE_W-1:0] ov_recovery_threshold;
        logic [`CVP_CODE_W-1:0] uv_threshold;
        logic [`CVP_CODE_W-1:0] uv_recovery_threshold;
        logic [`CVP_CODE_W-1:0] sleep_level_threshold;
        logic [`CVP_CODE_W-1:0] precharge_threshold;
        logic [`CVP_TMR_W-1:0]  ov_timer_code;
        logic [`CVP_TMR_W-1:0]  uv_timer_code;
        logic [`CVP_TMR_W-1:0]  sleep_timer_code;
    } cvp_cfg_t;

    // Status flags toward FET and power-state control
    typedef struct packed {
        logic ov;
        logic uv;
        logic ov_lockout;
        logic uv_lockout;
        logic sleep_level;
        logic precharge;
    } cvp_status_t;

    // Qualification timer state
    typedef struct packed {
        logic [`CVP_TCNT_W-1:0] cnt;
    } cvp_tmr_state_t;

    // Main block state
    typedef struct packed {
        cvp_cfg_t               cfg;
        cvp_status_t            status;
        cvp_prot_t              ov_state;
        cvp_prot_t              uv_state;
        logic                   ov_cond;
        logic                   uv_cond;
        logic                   sleep_cond;
        logic [`CVP_LO_W-1:0]   ovlo_cnt;
        logic [`CVP_LO_W-1:0]   uvlo_cnt;
        logic [`CVP_PRE_W-1:0]  pre_cnt;
        logic [`CVP_SEC_W-1:0]  sec_cnt;
        logic                   tick_ms;
        logic                   tick_s;
    } cvp_state_t;

endpackage

// file: core/cvp_protect.sv
// Cell voltage protection: thresholds, lockouts, timers and status flags
// Function
// - Thresholds are 12-bit codes over 0 V to 4.8 V, compared per cell.
// - Overvoltage lockout on any cell above limit; clears when all below recovery.
// - Undervoltage lockout on any cell below limit; clears when all above recovery.
// - Lockouts need five consecutive samples beyond limit in normal mode.
// - Overvoltage detected when any cell stays above threshold for timer duration.
// - Overvoltage released when all cells stay below recovery for same timer.
// - Overvoltage timer: 10-bit count with 1 ms or 1 s step.
// - Undervoltage detected when any cell stays below threshold for timer duration.
// - Undervoltage released when all cells rise above recovery code.
// - Undervoltage timer: 10-bit count with 1 ms or 1 s step.
// - Undervoltage release waits programmed time plus three extra seconds.
// - Sleep level flagged when any cell falls below sleep threshold.
// - Sleep level qualified by its own 10-bit ms or s timer.
// - Precharge requested while any cell is below precharge threshold.
`timescale 1ns/1ps
`include "cvp_consts.svh"
module cvp_protect
    import cvp_pkg::*;
#(
    parameter int N_CELLS   = 8,
    parameter int MS_CYCLES = `CVP_MS_PS / `CVP_CLK_PERIOD_PS
)
(
    // Clock and reset
    input  wire logic                            i_clock,
    input  wire logic                            i_rst_n,
    // Configuration load
    input  wire logic                            i_cfg_load,
    input  wire cvp_cfg_t                        i_cfg,
    // Cell scan results
    input  wire logic                            i_sample_valid,
    input  wire logic [N_CELLS*`CVP_CODE_W-1:0]  i_cells,
    // Status and config readback
    output cvp_status_t                          o_status,
    output cvp_cfg_t                             o_cfg
);

    localparam logic [`CVP_PRE_W-1:0] PRE_LAST = `CVP_PRE_W'(MS_CYCLES - 1);
    localparam logic [`CVP_SEC_W-1:0] SEC_LAST = `CVP_SEC_W'(`CVP_MS_PER_S - 1);
    localparam logic [`CVP_LO_W-1:0]  LO_LAST  = `CVP_LO_W'(`CVP_LO_SAMPLES - 1);

    localparam cvp_cfg_t CFG_RESET = '{
        ov_lockout_threshold:  `CVP_DEF_OVLO,
        uv_lockout_threshold:  `CVP_DEF_UVLO,
        ov_threshold:          `CVP_DEF_OV,
        ov_recovery_threshold: `CVP_DEF_OVR,
        uv_threshold:          `CVP_DEF_UV,
        uv_recovery_threshold: `CVP_DEF_UVR,
        sleep_level_threshold: `CVP_DEF_SLV,
        precharge_threshold:   `CVP_DEF_LVCH,
        ov_timer_code:         `CVP_DEF_TMR,
        uv_timer_code:         `CVP_DEF_TMR,
        sleep_timer_code:      `CVP_DEF_TMR
    };

    cvp_state_t s_q;
    cvp_state_t s_d;
    logic       ovlo_hit;
    logic       uvlo_hit;
    logic       ovr_all;
    logic       uvr_all;
    logic       ov_hit;
    logic       uv_hit;
    logic       slp_hit;
    logic       pre_hit;
    logic       ov_done;
    logic       uv_done;
    logic       slp_done;
    logic [1:0] uv_extra;

    // Per-cell compare: rising tests above, else below; any or all cells
    function automatic logic cell_hit(
        input logic [N_CELLS*`CVP_CODE_W-1:0] v,
        input logic [`CVP_CODE_W-1:0]         th,
        input logic                           rising,
        input logic                           want_any
    );
        logic r;
        logic c;
        r = !want_any;
        for (int i = 0; i < N_CELLS; i++)
        begin
            c = rising ? (v[i*`CVP_CODE_W +: `CVP_CODE_W] > th)
                       : (v[i*`CVP_CODE_W +: `CVP_CODE_W] < th);
            r = want_any ? (r | c) : (r & c);
        end
        return r;
    endfunction

    assign ovlo_hit = cell_hit(i_cells, s_q.cfg.ov_lockout_threshold, 1'b1, 1'b1);
    assign uvlo_hit = cell_hit(i_cells, s_q.cfg.uv_lockout_threshold, 1'b0, 1'b1);
    assign ovr_all  = cell_hit(i_cells, s_q.cfg.ov_recovery_threshold, 1'b0, 1'b0);
    assign uvr_all  = cell_hit(i_cells, s_q.cfg.uv_recovery_threshold, 1'b1, 1'b0);
    assign ov_hit   = cell_hit(i_cells, s_q.cfg.ov_threshold, 1'b1, 1'b1);
    assign uv_hit   = cell_hit(i_cells, s_q.cfg.uv_threshold, 1'b0, 1'b1);
    assign slp_hit  = cell_hit(i_cells, s_q.cfg.sleep_level_threshold, 1'b0, 1'b1);
    assign pre_hit  = cell_hit(i_cells, s_q.cfg.precharge_threshold, 1'b0, 1'b1);

    assign uv_extra = (s_q.uv_state == CVP_TRIP) ? 2'(`CVP_UV_REL_EXTRA_S) : 2'h0;

    cvp_qual_timer u_ov_timer (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_tick_ms (s_q.tick_ms),
        .i_tick_s  (s_q.tick_s),
        .i_cond    (s_q.ov_cond),
        .i_code    (s_q.cfg.ov_timer_code),
        .i_extra_s (2'h0),
        .o_done    (ov_done)
    );

    cvp_qual_timer u_uv_timer (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_tick_ms (s_q.tick_ms),
        .i_tick_s  (s_q.tick_s),
        .i_cond    (s_q.uv_cond),
        .i_code    (s_q.cfg.uv_timer_code),
        .i_extra_s (uv_extra),
        .o_done    (uv_done)
    );

    cvp_qual_timer u_slp_timer (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_tick_ms (s_q.tick_ms),
        .i_tick_s  (s_q.tick_s),
        .i_cond    (s_q.sleep_cond),
        .i_code    (s_q.cfg.sleep_timer_code),
        .i_extra_s (2'h0),
        .o_done    (slp_done)
    );

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        // Millisecond and second ticks from the core clock
        s_d.tick_ms = 1'b0;
        s_d.tick_s  = 1'b0;
        if (s_q.pre_cnt == PRE_LAST)
        begin
            s_d.pre_cnt = '0;
            s_d.tick_ms = 1'b1;
            if (s_q.sec_cnt == SEC_LAST)
            begin
                s_d.sec_cnt = '0;
                s_d.tick_s  = 1'b1;
            end
            else
                s_d.sec_cnt = s_q.sec_cnt + `CVP_SEC_W'(1);
        end
        else
            s_d.pre_cnt = s_q.pre_cnt + `CVP_PRE_W'(1);

        // new thresholds take effect from the next sample
        if (i_cfg_load)
            s_d.cfg = i_cfg;

        // Conditions are sampled per scan and held between scans
        if (i_sample_valid)
        begin
            s_d.ov_cond    = (s_q.ov_state == CVP_CLEAR) ? ov_hit : ovr_all;
            s_d.uv_cond    = (s_q.uv_state == CVP_CLEAR) ? uv_hit : uvr_all;
            s_d.sleep_cond = slp_hit;
            s_d.status.precharge = pre_hit;

            if (!s_q.status.ov_lockout)
            begin
                if (!ovlo_hit)
                    s_d.ovlo_cnt = '0;
                else if (s_q.ovlo_cnt == LO_LAST)
                begin
                    s_d.ovlo_cnt          = '0;
                    s_d.status.ov_lockout = 1'b1;
                end
                else
                    s_d.ovlo_cnt = s_q.ovlo_cnt + `CVP_LO_W'(1);
            end
            else if (ovr_all)
                s_d.status.ov_lockout = 1'b0;

            if (!s_q.status.uv_lockout)
            begin
                if (!uvlo_hit)
                    s_d.uvlo_cnt = '0;
                else if (s_q.uvlo_cnt == LO_LAST)
                begin
                    s_d.uvlo_cnt          = '0;
                    s_d.status.uv_lockout = 1'b1;
                end
                else
                    s_d.uvlo_cnt = s_q.uvlo_cnt + `CVP_LO_W'(1);
            end
            else if (uvr_all)
                s_d.status.uv_lockout = 1'b0;
        end

        // overvoltage and undervoltage states toggle; cond cleared so timer restarts
        case (s_q.ov_state)
            CVP_CLEAR, CVP_TRIP:
                if (ov_done)
                begin
                    s_d.ov_state = (s_q.ov_state == CVP_CLEAR) ? CVP_TRIP : CVP_CLEAR;
                    s_d.ov_cond  = 1'b0;
                end
            default:
                s_d.ov_state = CVP_CLEAR;
        endcase
        case (s_q.uv_state)
            CVP_CLEAR, CVP_TRIP:
                if (uv_done)
                begin
                    s_d.uv_state = (s_q.uv_state == CVP_CLEAR) ? CVP_TRIP : CVP_CLEAR;
                    s_d.uv_cond  = 1'b0;
                end
            default:
                s_d.uv_state = CVP_CLEAR;
        endcase
        s_d.status.ov = (s_d.ov_state == CVP_TRIP);
        s_d.status.uv = (s_d.uv_state == CVP_TRIP);
        // sleep flag drops as soon as the condition does
        s_d.status.sleep_level = slp_done;
    end

    // State register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_q     <= '0;
            s_q.cfg <= CFG_RESET;
        end
        else
            s_q <= s_d;
    end

    assign o_status = s_q.status;
    assign o_cfg    = s_q.cfg;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_ovlo_set_count: assert property ($rose(o_status.ov_lockout) |->
        $past(s_q.ovlo_cnt) == LO_LAST && $past(i_sample_valid && ovlo_hit))
        else $error("ov lockout set without five samples");
    a_ovlo_release: assert property ($fell(o_status.ov_lockout) |-> $past(i_sample_valid && ovr_all))
        else $error("ov lockout cleared without all cells recovered");
    a_uvlo_release: assert property ($fell(o_status.uv_lockout) |-> $past(i_sample_valid && uvr_all))
        else $error("uv lockout cleared without all cells recovered");
    a_uvlo_set_count: assert property ($rose(o_status.uv_lockout) |->
        $past(s_q.uvlo_cnt) == LO_LAST && $past(i_sample_valid && uvlo_hit))
        else $error("uv lockout set without five samples");
    a_ov_trip_cause: assert property ($rose(o_status.ov) |-> $past(s_q.ov_state == CVP_CLEAR && ov_done))
        else $error("ov set without qualified condition");
    a_ov_release_cause: assert property ($fell(o_status.ov) |-> $past(ov_done && s_q.ov_cond))
        else $error("ov released without qualified recovery");
    a_uv_trip_cause: assert property ($rose(o_status.uv) |-> $past(uv_done && uv_extra == 2'h0))
        else $error("uv set without qualified condition");
    a_uv_release_cause: assert property ($fell(o_status.uv) |-> $past(uv_done && uv_extra != 2'h0))
        else $error("uv released without qualified recovery");
    a_precharge_track: assert property (i_sample_valid |=> o_status.precharge == $past(pre_hit))
        else $error("precharge flag does not follow sample");
    a_sleep_drop: assert property (!s_q.sleep_cond |=> !o_status.sleep_level)
        else $error("sleep flag held after condition dropped");
    a_cfg_load: assert property (i_cfg_load |=> o_cfg == $past(i_cfg))
        else $error("configuration not loaded");

    c_ov_trip: cover property ($rose(o_status.ov));
    c_uv_release: cover property ($fell(o_status.uv));
    c_ovlo_set: cover property ($rose(o_status.ov_lockout));
    c_sleep_set: cover property ($rose(o_status.sleep_level));

endmodule

// file: core/cvp_qual_timer.sv
// Qualification timer: counts ms or s ticks while a condition holds
`timescale 1ns/1ps
`include "cvp_consts.svh"
module cvp_qual_timer
    import cvp_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_n,
    // Time base
    input  wire logic                   i_tick_ms,
    input  wire logic                   i_tick_s,
    // Qualification request
    input  wire logic                   i_cond,
    input  wire logic [`CVP_TMR_W-1:0]  i_code,
    input  wire logic [1:0]             i_extra_s,
    // Result
    output logic                        o_done
);

    cvp_tmr_state_t         s_q;
    cvp_tmr_state_t         s_d;
    logic                   unit_s;
    logic [`CVP_TCNT_W-1:0] target;
    logic                   tick;

    // code decode
    // Count is split around the unit bit so the reset code means one second
    assign unit_s = i_code[`CVP_TMR_UNIT_BIT];
    assign target = `CVP_TCNT_W'({i_code[`CVP_TMR_MSB_BIT], i_code[`CVP_TMR_LOW_MSB:0]})
                  + (unit_s ? `CVP_TCNT_W'(i_extra_s)
                            : `CVP_TCNT_W'(i_extra_s) * `CVP_TCNT_W'(`CVP_MS_PER_S));
    assign tick   = unit_s ? i_tick_s : i_tick_ms;

    always_comb
    begin
        s_d = s_q;
        if (!i_cond)
            s_d.cnt = '0;
        else if (tick && s_q.cnt < target)
            s_d.cnt = s_q.cnt + `CVP_TCNT_W'(1);
    end

    // Done is combinational; the caller registers its flags
    assign o_done = i_cond && (s_q.cnt >= target);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_tmr_restart_drop: assert property (!i_cond |=> s_q.cnt == '0)
        else $error("timer did not restart after condition dropped");
    // Three seconds is 3 s ticks or 3000 ms ticks, whatever the programmed count
    a_tmr_extra_hold: assert property ((i_extra_s != 2'h0) && s_q.cnt < (unit_s ? 12'h003 : 12'hBB8) |-> !o_done)
        else $error("release done before extra delay");

endmodule

// file: tb/test_cell_voltage_protection_logic.sv
// Self-checking testbench for the cell voltage protection logic
`timescale 1ns/1ps
`include "cvp_consts.svh"
module test_cell_voltage_protection_logic
    import cvp_pkg::*;
;
    // Short ms tick keeps the run small: 1 ms = 4 cycles, 1 s = 4000 cycles
    localparam int NC     = 8;
    localparam int CW     = `CVP_CODE_W;
    localparam int MSC    = 4;
    localparam int LIMIT  = 40000;
    localparam int B_OV   = 5;
    localparam int B_UV   = 4;
    localparam int B_OVLO = 3;
    localparam int B_UVLO = 2;
    localparam int B_SLP  = 1;
    localparam int B_PRE  = 0;
    localparam logic [CW-1:0] NOM = 12'hC00;

    logic                i_clock;
    logic                i_rst_n;
    logic                i_cfg_load;
    cvp_cfg_t            i_cfg;
    logic                i_sample_valid;
    logic [NC*CW-1:0]    i_cells;
    cvp_status_t         o_status;
    cvp_cfg_t            o_cfg;
    int                  errors;
    int                  checks;
    int                  cycles;
    cvp_cfg_t            def_cfg;
    cvp_cfg_t            run_cfg;
    cvp_cfg_t            sec_cfg;

    cvp_protect #(
        .N_CELLS   (NC),
        .MS_CYCLES (MSC)
    ) dut (
        .i_clock        (i_clock),
        .i_rst_n        (i_rst_n),
        .i_cfg_load     (i_cfg_load),
        .i_cfg          (i_cfg),
        .i_sample_valid (i_sample_valid),
        .i_cells        (i_cells),
        .o_status       (o_status),
        .o_cfg          (o_cfg)
    );

    // Free running 250 MHz clock
    initial
    begin
        i_clock = 1'h0;
        forever #2 i_clock = ~i_clock;
    end

    // Hang guard: counts as a mismatch, then closes the run
    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge i_clock);
            cycles++;
            if (cycles >= LIMIT)
            begin
                errors++;
                $display("MISMATCH at %0t: run exceeded cycle limit", $time);
                print_verdict();
            end
        end
    end

    task automatic print_verdict();
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic fail(input string msg);
        errors++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask

    // All driving happens 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // One scan pulse, then a spare cycle so valid never toggles twice per step
    task automatic sample(input logic [NC*CW-1:0] v);
        i_cells        = v;
        i_sample_valid = 1'h1;
        tick(1);
        i_sample_valid = 1'h0;
        tick(1);
    endtask

    function automatic logic [NC*CW-1:0] cells(input logic [CW-1:0] base, input int idx,
                                               input logic [CW-1:0] odd);
        logic [NC*CW-1:0] v;
        v = {NC{base}};
        v[idx*CW +: CW] = odd;
        return v;
    endfunction

    task automatic check_bit(input int idx, input logic exp, input string msg);
        checks++;
        if (o_status[idx] !== exp)
            fail(msg);
    endtask

    // Flag must keep its value for n cycles; catches early firing
    task automatic hold_bit(input int idx, input logic exp, input int n, input string msg);
        bit bad;
        bad = 1'b0;
        checks++;
        repeat (n)
        begin
            if (o_status[idx] !== exp)
                bad = 1'b1;
            tick(1);
        end
        if (bad)
            fail(msg);
    endtask

    // Bounded wait for a flag, since tick phase makes the exact cycle vary
    task automatic wait_bit(input int idx, input logic exp, input int max, input string msg);
        int n;
        n = 0;
        checks++;
        while (o_status[idx] !== exp && n < max)
        begin
            tick(1);
            n++;
        end
        if (o_status[idx] !== exp)
            fail(msg);
    endtask

    // Reset, then load a configuration; each scenario starts from clean state
    task automatic restart(input cvp_cfg_t c);
        i_rst_n = 1'h0;
        tick(4);
        i_rst_n = 1'h1;
        tick(1);
        i_cfg      = c;
        i_cfg_load = 1'h1;
        tick(1);
        i_cfg_load = 1'h0;
        tick(1);
    endtask

    // Main sequence
    initial
    begin
        errors         = 0;
        checks         = 0;
        i_rst_n        = 1'h0;
        i_cfg_load     = 1'h0;
        i_sample_valid = 1'h0;
        i_cells        = '0;
        def_cfg = '{ov_lockout_threshold: `CVP_DEF_OVLO, uv_lockout_threshold: `CVP_DEF_UVLO,
                    ov_threshold: `CVP_DEF_OV, ov_recovery_threshold: `CVP_DEF_OVR,
                    uv_threshold: `CVP_DEF_UV, uv_recovery_threshold: `CVP_DEF_UVR,
                    sleep_level_threshold: `CVP_DEF_SLV, precharge_threshold: `CVP_DEF_LVCH,
                    ov_timer_code: `CVP_DEF_TMR, uv_timer_code: `CVP_DEF_TMR,
                    sleep_timer_code: `CVP_DEF_TMR};
        i_cfg   = def_cfg;
        // Short ms timers: ov 5 ms, uv 4 ms, sleep 3 ms
        run_cfg = def_cfg;
        run_cfg.ov_timer_code    = 11'h005;
        run_cfg.uv_timer_code    = 11'h004;
        run_cfg.sleep_timer_code = 11'h003;
        // Second-unit timer: 2 s
        sec_cfg = run_cfg;
        sec_cfg.ov_timer_code    = 11'h202;
        tick(4);
        checks++;
        if (o_cfg !== def_cfg) fail("config reset values");
        checks++;
        if (o_status !== '0) fail("status not clear in reset");
        i_rst_n = 1'h1;
        tick(1);
        i_cfg      = run_cfg;
        i_cfg_load = 1'h1;
        tick(1);
        i_cfg_load = 1'h0;
        tick(1);
        checks++;
        if (o_cfg !== run_cfg) fail("config load");

        sample(cells(NOM, 3, 12'h7AA));
        check_bit(B_PRE, 1'h0, "precharge at threshold");
        sample(cells(NOM, 3, 12'h7A9));
        check_bit(B_PRE, 1'h1, "precharge below threshold");
        sample(cells(NOM, 0, NOM));
        check_bit(B_PRE, 1'h0, "precharge after recovery");

        // overvoltage lockout, boundary sample breaks the run
        restart(run_cfg);
        repeat (4) sample(cells(NOM, 7, 12'hE81));
        sample(cells(NOM, 7, 12'hE80));
        repeat (4) sample(cells(NOM, 7, 12'hE81));
        check_bit(B_OVLO, 1'h0, "ov lockout before fifth sample");
        sample(cells(NOM, 7, 12'hE81));
        check_bit(B_OVLO, 1'h1, "ov lockout after five samples");
        sample(cells(12'hDD4, 0, 12'hDD5));
        check_bit(B_OVLO, 1'h1, "ov lockout cleared at recovery code");
        sample(cells(12'hDD4, 0, 12'hDD4));
        check_bit(B_OVLO, 1'h0, "ov lockout not cleared");

        restart(run_cfg);
        repeat (4) sample(cells(NOM, 2, 12'h5FF));
        check_bit(B_UVLO, 1'h0, "uv lockout before fifth sample");
        sample(cells(NOM, 2, 12'h5FF));
        check_bit(B_UVLO, 1'h1, "uv lockout after five samples");
        sample(cells(12'hA01, 5, 12'hA00));
        check_bit(B_UVLO, 1'h1, "uv lockout cleared at recovery code");
        sample(cells(12'hA01, 5, 12'hA01));
        check_bit(B_UVLO, 1'h0, "uv lockout not cleared");

        // overvoltage timer with an interrupted condition
        restart(run_cfg);
        sample(cells(NOM, 1, 12'hE2B));
        hold_bit(B_OV, 1'h0, 12, "ov set too early");
        sample(cells(NOM, 1, 12'hE2A));
        sample(cells(NOM, 1, 12'hE2B));
        hold_bit(B_OV, 1'h0, 12, "ov timer not restarted");
        wait_bit(B_OV, 1'h1, 20, "ov not set");
        sample(cells(12'hDD4, 4, 12'hDD5));
        hold_bit(B_OV, 1'h1, 30, "ov released at recovery code");
        sample(cells(12'hDD4, 4, 12'hDD4));
        hold_bit(B_OV, 1'h1, 12, "ov released too early");
        wait_bit(B_OV, 1'h0, 20, "ov not released");

        restart(sec_cfg);
        sample(cells(NOM, 6, 12'hFFF));
        // Tick counters restart with reset, so the second tick lands at a known cycle
        hold_bit(B_OV, 1'h0, 7990, "ov seconds timer too short");
        wait_bit(B_OV, 1'h1, 200, "ov seconds timer too long");

        restart(run_cfg);
        sample(cells(NOM, 6, 12'h8FF));
        hold_bit(B_UV, 1'h0, 10, "uv set too early");
        wait_bit(B_UV, 1'h1, 20, "uv not set");
        sample(cells(12'hA01, 6, 12'hA00));
        hold_bit(B_UV, 1'h1, 40, "uv released at recovery code");
        sample(cells(12'hA01, 6, 12'hA01));
        hold_bit(B_UV, 1'h1, 11950, "uv released without extra time");
        wait_bit(B_UV, 1'h0, 200, "uv not released");

        // sleep level with its own timer
        restart(run_cfg);
        sample(cells(NOM, 0, 12'h6A9));
        hold_bit(B_SLP, 1'h0, 6, "sleep set too early");
        wait_bit(B_SLP, 1'h1, 20, "sleep not set");
        sample(cells(NOM, 0, 12'h6AA));
        check_bit(B_SLP, 1'h0, "sleep held at threshold");

        print_verdict();
    end
endmodule
